/* File: hdl/ccr_pkg.sv */
/*
 * Package for the calendar clock register block: register offsets, field
 * positions, counting limits and timing counts.
 * Assumes a single 100 MHz clock and a byte-wide register port.
 */
package ccr_pkg;
  // ==========================================================
  // register offsets (byte addresses on the register port)
  localparam logic [11:0] CCR_SECONDS_COUNT   = 12'h320;
  localparam logic [11:0] CCR_MINUTES_COUNT   = 12'h321;
  localparam logic [11:0] CCR_HOURS_COUNT     = 12'h322;
  localparam logic [11:0] CCR_WEEKDAY_COUNT   = 12'h323;
  localparam logic [11:0] CCR_MONTH_DAY_COUNT = 12'h324;
  localparam logic [11:0] CCR_MONTH_OR_FORMAT = 12'h325;
  localparam logic [11:0] CCR_YEAR_OR_LEAP    = 12'h326;
  localparam logic [11:0] CCR_PAGE_ENABLES    = 12'h327;
  localparam logic [11:0] CCR_CLOCK_RESET     = 12'h328;

  // ==========================================================
  // page register fields
  localparam int CCR_PG_PAGE   = 0;
  localparam int CCR_PG_ALARM  = 2;
  localparam int CCR_PG_COUNT  = 3;
  localparam int CCR_PG_ADJUST = 4;
  localparam int CCR_PG_IRQ    = 7;
  // reset control fields
  localparam int CCR_RS_ALARM  = 4;
  localparam int CCR_RS_COUNT  = 5;
  localparam int CCR_RS_16HZ   = 6;
  localparam int CCR_RS_1HZ    = 7;

  // ==========================================================
  // BCD limits
  localparam logic [6:0] CCR_SEC_MAX   = 7'h59;
  localparam logic [6:0] CCR_MIN_MAX   = 7'h59;
  localparam logic [5:0] CCR_H24_MAX   = 6'h23;
  localparam logic [4:0] CCR_H12_MAX   = 5'h12;
  localparam logic [2:0] CCR_WDAY_MAX  = 3'h6;
  localparam logic [4:0] CCR_MON_MAX   = 5'h12;
  localparam logic [7:0] CCR_YEAR_MAX  = 8'h99;

  // ==========================================================
  // timing
  localparam int CCR_CLK_HZ       = 100_000_000;
  localparam int CCR_SECOND_HZ    = 1;
  localparam int CCR_FAST_HZ      = 16;
  localparam int CCR_SEC_CYCLES   = CCR_CLK_HZ / CCR_SECOND_HZ;
  localparam int CCR_FAST_CYCLES  = CCR_CLK_HZ / CCR_FAST_HZ;
endpackage

/* File: hdl/ccr_calendar_clock.sv */
/*
 * Calendar and time-of-day counter with a two-page register set.
 * Assumes software drives a single-cycle byte register port on clock_i;
 * the tick parameter may be shortened for simulation.
 */
`timescale 1ns/1ps
module ccr_calendar_clock
  import ccr_pkg::*;
#(
  parameter int SEC_CYCLES  = CCR_SEC_CYCLES,
  parameter int FAST_CYCLES = CCR_FAST_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // register port
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // timekeeping outputs
  output logic             one_hertz_o,
  output logic             sixteen_hertz_o,
  output logic             alarm_enable_o,
  output logic             timekeeping_irq_enable_o,
  output logic             alarm_logic_reset_o
);

  // ==========================================================
  // register state
  logic [6:0] sec_q;
  logic [6:0] min_q;
  logic [5:0] hour_q;
  logic [2:0] wday_q;
  logic [5:0] date_q;
  logic [4:0] mon_q;
  logic [7:0] year_q;
  logic       fmt24_q;
  logic [1:0] leap_q;
  logic       page_q;
  logic       count_enable_q;
  logic       alarm_enable_q;
  logic       irq_enable_q;
  logic       one_hertz_enable_q;
  logic       sixteen_hertz_enable_q;
  logic       adjust_q;
  logic       alarm_reset_q;
  logic [31:0] sec_div_q;
  logic [31:0] fast_div_q;
  logic        one_hz_q;
  logic        fast_q;
  logic [7:0]  rdata_q;

  logic wr_any;
  logic count_logic_reset;
  logic tick;
  logic half_tick;
  logic fast_tick;

  assign wr_any            = wr_i;
  assign count_logic_reset = wr_i && addr_i == CCR_CLOCK_RESET && wdata_i[CCR_RS_COUNT];

  // ==========================================================
  // prescalers
  // adjust rounds the sub-second phase: restart the second on request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_div_q <= 32'h0;
    end else if (count_logic_reset || adjust_q) begin
      sec_div_q <= 32'h0;
    end else if (count_enable_q) begin
      if (sec_div_q == 32'(SEC_CYCLES - 1)) begin
        sec_div_q <= 32'h0;
      end else begin
        sec_div_q <= sec_div_q + 32'h1;
      end
    end
  end

  assign tick = count_enable_q && !count_logic_reset && !adjust_q &&
                sec_div_q == 32'(SEC_CYCLES - 1);

  // gated like tick: a prescaler parked at mid count must not toggle every cycle
  assign half_tick = count_enable_q && !count_logic_reset && !adjust_q &&
                     sec_div_q == 32'(SEC_CYCLES / 2 - 1);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_div_q <= 32'h0;
    end else if (fast_div_q == 32'(FAST_CYCLES / 2 - 1)) begin
      fast_div_q <= 32'h0;
    end else begin
      fast_div_q <= fast_div_q + 32'h1;
    end
  end

  assign fast_tick = fast_div_q == 32'(FAST_CYCLES / 2 - 1);

  // square waves, gated by their enables
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      one_hz_q <= 1'b0;
      fast_q   <= 1'b0;
    end else begin
      if (fast_tick) begin
        fast_q <= ~fast_q;
      end
      if (half_tick || tick) begin
        one_hz_q <= ~one_hz_q;
      end
    end
  end

  assign one_hertz_o     = one_hz_q && one_hertz_enable_q;
  assign sixteen_hertz_o = fast_q && sixteen_hertz_enable_q;

  // ==========================================================
  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic [5:0] month_len(input logic [4:0] m, input logic leap);
    case (m)
      5'h02:                        month_len = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11:   month_len = 6'h30;
      default:                      month_len = 6'h31;
    endcase
  endfunction

  // leap year when the leap counter wraps to zero
  logic       is_leap;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hour_wrap;
  logic       date_wrap;
  logic       mon_wrap;
  logic [5:0] hour_next;

  assign is_leap  = leap_q == 2'h0;
  assign sec_wrap = sec_q == CCR_SEC_MAX;
  assign min_wrap = min_q == CCR_MIN_MAX;

  logic [7:0] sec_inc;
  logic [7:0] min_inc;
  logic [7:0] hour_inc;
  logic [7:0] h12_inc;
  logic [7:0] date_inc;
  logic [7:0] mon_inc;

  assign sec_inc  = bcd_inc({1'b0, sec_q});
  assign min_inc  = bcd_inc({1'b0, min_q});
  assign hour_inc = bcd_inc({2'h0, hour_q});
  assign h12_inc  = bcd_inc({3'h0, hour_q[4:0]});
  assign date_inc = bcd_inc({2'h0, date_q});
  assign mon_inc  = bcd_inc({3'h0, mon_q});

  // 12-hour: 12 -> 1 toggles nothing, 11 -> 12 flips the PM flag
  always_comb begin
    hour_wrap = 1'b0;
    hour_next = 6'h0;
    if (fmt24_q) begin
      hour_wrap = hour_q == CCR_H24_MAX;
      hour_next = hour_wrap ? 6'h0 : hour_inc[5:0];
    end else if (hour_q[4:0] == CCR_H12_MAX) begin
      hour_next = {hour_q[5], 5'h01};
    end else if (hour_q[4:0] == 5'h11) begin
      hour_wrap = hour_q[5];
      hour_next = {~hour_q[5], CCR_H12_MAX};
    end else begin
      hour_next = {hour_q[5], h12_inc[4:0]};
    end
  end

  assign date_wrap = date_q == month_len(mon_q, is_leap);
  assign mon_wrap  = mon_q == CCR_MON_MAX;

  // ==========================================================
  // write decode
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_wday;
  logic wr_date;
  logic wr_mon;
  logic wr_year;

  assign wr_sec  = wr_any && addr_i == CCR_SECONDS_COUNT;
  assign wr_min  = wr_any && addr_i == CCR_MINUTES_COUNT;
  assign wr_hour = wr_any && addr_i == CCR_HOURS_COUNT;
  assign wr_wday = wr_any && addr_i == CCR_WEEKDAY_COUNT;
  assign wr_date = wr_any && addr_i == CCR_MONTH_DAY_COUNT;
  assign wr_mon  = wr_any && addr_i == CCR_MONTH_OR_FORMAT;
  assign wr_year = wr_any && addr_i == CCR_YEAR_OR_LEAP;

  // ==========================================================
  // time counters; a software write beats a carry in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_q  <= 7'h0;
      min_q  <= 7'h0;
      hour_q <= 6'h0;
    end else begin
      if (wr_sec) begin
        sec_q <= wdata_i[6:0];
      end else if (tick) begin
        sec_q <= sec_wrap ? 7'h0 : sec_inc[6:0];
      end
      if (wr_min) begin
        min_q <= wdata_i[6:0];
      end else if (tick && sec_wrap) begin
        min_q <= min_wrap ? 7'h0 : min_inc[6:0];
      end
      if (wr_hour) begin
        hour_q <= wdata_i[5:0];
      end else if (tick && sec_wrap && min_wrap) begin
        hour_q <= hour_next;
      end
    end
  end

  logic day_carry;
  assign day_carry = tick && sec_wrap && min_wrap && hour_wrap;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wday_q <= 3'h0;
      date_q <= 6'h01;
      mon_q  <= 5'h01;
      year_q <= 8'h0;
      leap_q <= 2'h0;
    end else begin
      if (wr_wday) begin
        wday_q <= wdata_i[2:0];
      end else if (day_carry) begin
        wday_q <= wday_q == CCR_WDAY_MAX ? 3'h0 : wday_q + 3'h1;
      end
      if (wr_date) begin
        date_q <= wdata_i[5:0];
      end else if (day_carry) begin
        date_q <= date_wrap ? 6'h01 : date_inc[5:0];
      end
      if (wr_mon && !page_q) begin
        mon_q <= wdata_i[4:0];
      end else if (day_carry && date_wrap) begin
        mon_q <= mon_wrap ? 5'h01 : mon_inc[4:0];
      end
      if (wr_year && !page_q) begin
        year_q <= wdata_i;
      end else if (day_carry && date_wrap && mon_wrap) begin
        year_q <= year_q == CCR_YEAR_MAX ? 8'h0 : bcd_inc(year_q);
      end
      if (wr_year && page_q) begin
        leap_q <= wdata_i[1:0];
      end else if (day_carry && date_wrap && mon_wrap) begin
        leap_q <= leap_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // page register and reset register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_q         <= 1'b0;
      count_enable_q <= 1'b0;
      alarm_enable_q <= 1'b0;
      irq_enable_q   <= 1'b0;
      adjust_q       <= 1'b0;
      fmt24_q        <= 1'b0;
    end else begin
      adjust_q <= 1'b0;
      if (wr_any && addr_i == CCR_PAGE_ENABLES) begin
        page_q         <= wdata_i[CCR_PG_PAGE];
        alarm_enable_q <= wdata_i[CCR_PG_ALARM];
        count_enable_q <= wdata_i[CCR_PG_COUNT];
        adjust_q       <= wdata_i[CCR_PG_ADJUST];
        irq_enable_q   <= wdata_i[CCR_PG_IRQ];
      end
      if (wr_mon && page_q) begin
        fmt24_q <= wdata_i[0];
      end
    end
  end

  // low bits ignored; software keeps them zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      one_hertz_enable_q     <= 1'b0;
      sixteen_hertz_enable_q <= 1'b0;
      alarm_reset_q          <= 1'b0;
    end else begin
      alarm_reset_q <= 1'b0;
      if (wr_any && addr_i == CCR_CLOCK_RESET) begin
        one_hertz_enable_q     <= wdata_i[CCR_RS_1HZ];
        sixteen_hertz_enable_q <= wdata_i[CCR_RS_16HZ];
        alarm_reset_q          <= wdata_i[CCR_RS_ALARM];
      end
    end
  end

  assign alarm_enable_o           = alarm_enable_q;
  assign timekeeping_irq_enable_o = irq_enable_q;
  assign alarm_logic_reset_o      = alarm_reset_q;

  // ==========================================================
  // read path; write-only and unmapped addresses return zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h0;
    end else if (rd_i) begin
      case (addr_i)
        CCR_SECONDS_COUNT:   rdata_q <= {1'b0, sec_q};
        CCR_MINUTES_COUNT:   rdata_q <= {1'b0, min_q};
        CCR_HOURS_COUNT:     rdata_q <= {2'h0, hour_q};
        CCR_WEEKDAY_COUNT:   rdata_q <= {5'h0, wday_q};
        CCR_MONTH_DAY_COUNT: rdata_q <= {2'h0, date_q};
        CCR_MONTH_OR_FORMAT: rdata_q <= page_q ? {7'h0, fmt24_q} : {3'h0, mon_q};
        CCR_YEAR_OR_LEAP:    rdata_q <= page_q ? {6'h0, leap_q} : year_q;
        CCR_PAGE_ENABLES:    rdata_q <= {irq_enable_q, 3'h0, count_enable_q,
                                         alarm_enable_q, 1'b0, page_q};
        default:             rdata_q <= 8'h0;
      endcase
    end else begin
      rdata_q <= 8'h0;
    end
  end

  assign rdata_o = rdata_q;

endmodule

/* File: dv/ccr_checker.sv */
/*
 * Port checker for the calendar clock register block.
 * Assumes it is bound to ccr_calendar_clock and sees only its ports.
 */
`timescale 1ns/1ps
module ccr_checker
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        nrst_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // timekeeping outputs
  input wire logic        one_hertz_o,
  input wire logic        sixteen_hertz_o,
  input wire logic        alarm_enable_o,
  input wire logic        timekeeping_irq_enable_o,
  input wire logic        alarm_logic_reset_o
);
  // ==========================================================
  // shadow of the output enables, loaded on the same edge as the block's own enables
  logic [1:0] hz_en_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hz_en_q <= 2'b00;
    end else if (wr_i && addr_i == CCR_CLOCK_RESET) begin
      hz_en_q <= wdata_i[7:6];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // read masks
  property p_wo_read;
    rd_i && (addr_i == CCR_CLOCK_RESET || addr_i > 12'h328 || addr_i < 12'h320)
      |=> rdata_o == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");
  property p_secmin; rd_i && addr_i inside {12'h320, 12'h321} |=> !rdata_o[7]; endproperty
  a_secmin: assert property (p_secmin) else $error("sec or min bit 7 set");
  property p_hour_date;
    rd_i && addr_i inside {12'h322, 12'h324} |=> rdata_o[7:6] == 2'b00;
  endproperty
  a_hour_date: assert property (p_hour_date) else $error("hour or date top bits");
  property p_wday; rd_i && addr_i == 12'h323 |=> rdata_o[7:3] == 5'h00; endproperty
  a_wday: assert property (p_wday) else $error("weekday top bits");
  property p_month; rd_i && addr_i == 12'h325 |=> rdata_o[7:5] == 3'h0; endproperty
  a_month: assert property (p_month) else $error("month top bits");
  property p_page_rd;
    rd_i && addr_i == 12'h327 |=> rdata_o[6:4] == 3'h0 && !rdata_o[1];
  endproperty
  a_page_rd: assert property (p_page_rd) else $error("page reg zero bits");
  // ==========================================================
  // enables and pulses
  property p_enables;
    wr_i && addr_i == CCR_PAGE_ENABLES |=> alarm_enable_o == $past(wdata_i[CCR_PG_ALARM])
      && timekeeping_irq_enable_o == $past(wdata_i[CCR_PG_IRQ]);
  endproperty
  a_enables: assert property (p_enables) else $error("enable outputs wrong");
  property p_en_hold;
    !(wr_i && addr_i == CCR_PAGE_ENABLES)
      |=> $stable(alarm_enable_o) && $stable(timekeeping_irq_enable_o);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved alone");
  property p_alarm_rst;
    alarm_logic_reset_o == $past(wr_i && addr_i == CCR_CLOCK_RESET && wdata_i[CCR_RS_ALARM]);
  endproperty
  a_alarm_rst: assert property (p_alarm_rst) else $error("alarm reset pulse wrong");
  property p_hz_off; !hz_en_q[1] [*3] |-> !one_hertz_o; endproperty
  a_hz_off: assert property (p_hz_off) else $error("1 Hz while disabled");
  property p_16_off; !hz_en_q[0] [*3] |-> !sixteen_hertz_o; endproperty
  a_16_off: assert property (p_16_off) else $error("16 Hz while disabled");
endmodule

bind ccr_calendar_clock ccr_checker u_chk (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .one_hertz_o, .sixteen_hertz_o, .alarm_enable_o,
  .timekeeping_irq_enable_o, .alarm_logic_reset_o);

/* File: dv/tb_top.sv */
/*
 * Directed register-port testbench for the calendar clock block.
 * Assumes ccr_pkg and the design compile first; ticks are shortened.
 */
`timescale 1ns/1ps
module tb_top;
  import ccr_pkg::*;
  localparam int SEC = 20;
  logic        clock_i   = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [11:0] addr_i    = 12'h000;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [7:0]  rdata_o;
  logic        one_hz, fast_hz, alm_en, irq_en, alm_rst;
  logic [7:0]  v;
  int          err_total = 0;
  int          tests_run = 0;
  int          i;
  logic [7:0]  rst_e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0]  mw [7]    = '{8'hd9, 8'hd9, 8'he3, 8'hfe, 8'hf1, 8'hf2, 8'h99};
  logic [7:0]  me [7]    = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};

  ccr_calendar_clock #(.SEC_CYCLES(SEC), .FAST_CYCLES(8)) dut (.clock_i(clock_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .one_hertz_o(one_hz), .sixteen_hertz_o(fast_hz),
    .alarm_enable_o(alm_en), .timekeeping_irq_enable_o(irq_en),
    .alarm_logic_reset_o(alm_rst));

  always #5 clock_i = ~clock_i;

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e, $sformatf("read %h", a));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic fail_to();
    err_total++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    results();
  endtask
  // one second roll from hh:59:59, far end of the seconds and minutes chains
  task automatic roll(input logic [7:0] fmt, lp, h, d, m, y, wd, eh, ed, em, ey, ew);
    int n;
    wr(CCR_PAGE_ENABLES, 8'h01);
    wr(CCR_MONTH_OR_FORMAT, fmt);
    wr(CCR_YEAR_OR_LEAP, lp);
    wr(CCR_PAGE_ENABLES, 8'h00);
    wr(CCR_SECONDS_COUNT, 8'h59);
    wr(CCR_MINUTES_COUNT, 8'h59);
    wr(CCR_HOURS_COUNT, h);
    wr(CCR_WEEKDAY_COUNT, wd);
    wr(CCR_MONTH_DAY_COUNT, d);
    wr(CCR_MONTH_OR_FORMAT, m);
    wr(CCR_YEAR_OR_LEAP, y);
    wr(CCR_PAGE_ENABLES, 8'h08);
    v = 8'h59;
    for (n = 0; n < 4 * SEC && v === 8'h59; n++) rd(CCR_SECONDS_COUNT);
    if (v === 8'h59) fail_to();
    chk(v, 8'h00, "sec roll");
    rc(CCR_MINUTES_COUNT, 8'h00);
    rc(CCR_HOURS_COUNT, eh);
    rc(CCR_WEEKDAY_COUNT, ew);
    rc(CCR_MONTH_DAY_COUNT, ed);
    rc(CCR_MONTH_OR_FORMAT, em);
    rc(CCR_YEAR_OR_LEAP, ey);
    wr(CCR_PAGE_ENABLES, 8'h00);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 9; i++) rc(CCR_SECONDS_COUNT + 12'(i), rst_e[i]);
    rc(12'h329, 8'h00);
    $display("reset values done");
    for (i = 0; i < 7; i++) wr(CCR_SECONDS_COUNT + 12'(i), mw[i]);
    for (i = 0; i < 7; i++) rc(CCR_SECONDS_COUNT + 12'(i), me[i]);
    $display("field masks done");
    wr(CCR_PAGE_ENABLES, 8'h97);
    rc(CCR_PAGE_ENABLES, 8'h85);
    chk({6'h00, irq_en, alm_en}, 8'h03, "enables");
    wr(CCR_MONTH_OR_FORMAT, 8'hff);
    wr(CCR_YEAR_OR_LEAP, 8'hfe);
    rc(CCR_MONTH_OR_FORMAT, 8'h01);
    rc(CCR_YEAR_OR_LEAP, 8'h02);
    wr(CCR_PAGE_ENABLES, 8'h00);
    rc(CCR_MONTH_OR_FORMAT, 8'h12);
    rc(CCR_YEAR_OR_LEAP, 8'h99);
    $display("paging done");
    wr(CCR_CLOCK_RESET, 8'h10);
    #1 chk({7'h00, alm_rst}, 8'h01, "alarm reset pulse");
    wr(CCR_CLOCK_RESET, 8'h20);
    #1 chk({7'h00, alm_rst}, 8'h00, "alarm reset cleared");
    wr(CCR_PAGE_ENABLES, 8'h08);
    wr(CCR_CLOCK_RESET, 8'hc0);
    for (i = 0; i < 4 * SEC && one_hz !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (one_hz !== 1'b1) fail_to();
    for (i = 0; i < 40 && fast_hz !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (fast_hz !== 1'b1) fail_to();
    chk({6'h00, one_hz, fast_hz}, 8'h03, "hz on");
    wr(CCR_CLOCK_RESET, 8'h00);
    repeat (3) @(posedge clock_i);
    #1 chk({6'h00, one_hz, fast_hz}, 8'h00, "hz off");
    // counting still on: a count reset restarts the second from zero
    wr(CCR_CLOCK_RESET, 8'h20);
    wr(CCR_SECONDS_COUNT, 8'h00);
    repeat (SEC - 6) @(posedge clock_i);
    rc(CCR_SECONDS_COUNT, 8'h00);
    repeat (4) @(posedge clock_i);
    rc(CCR_SECONDS_COUNT, 8'h01);
    $display("reset register done");
    roll(8'h01, 8'h00, 8'h23, 8'h31, 8'h12, 8'h99, 8'h06, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00);
    roll(8'h00, 8'h00, 8'h11, 8'h15, 8'h06, 8'h10, 8'h02, 8'h32, 8'h15, 8'h06, 8'h10, 8'h02);
    roll(8'h01, 8'h00, 8'h23, 8'h28, 8'h02, 8'h24, 8'h03, 8'h00, 8'h29, 8'h02, 8'h24, 8'h04);
    roll(8'h01, 8'h01, 8'h23, 8'h28, 8'h02, 8'h25, 8'h05, 8'h00, 8'h01, 8'h03, 8'h25, 8'h06);
    $display("counting done");
    results();
  end
endmodule
